//--- inc/ea_decode_pkg.sv
// Constants and types for the general-format operand decoder
package ea_decode_pkg;
    // Addressing-mode prefixes, upper four bits of the first byte
    localparam logic [3:0] PFX_REG_DIRECT  = 4'hA;
    localparam logic [3:0] PFX_PREDEC      = 4'hB;
    localparam logic [3:0] PFX_POSTINC     = 4'hC;
    localparam logic [3:0] PFX_REG_IND     = 4'hD;
    localparam logic [3:0] PFX_DISP8       = 4'hE;
    localparam logic [3:0] PFX_DISP16      = 4'hF;
    localparam logic [3:0] PFX_ABS8        = 4'h0;
    localparam logic [3:0] PFX_ABS16       = 4'h1;
    // Low three bits that complete an absolute mode byte
    localparam logic [2:0] ABS_LOW_BITS    = 3'h5;
    // Immediate mode bytes
    localparam logic [7:0] IMM8_BYTE       = 8'h04;
    localparam logic [7:0] IMM16_BYTE      = 8'h0C;
    // Field positions in the mode byte
    localparam int         SIZE_BIT_POS    = 3;
    localparam int         REG_MSB         = 2;
    // Opcode prefix of general add, upper five bits
    localparam logic [4:0] OP_ADD_PREFIX   = 5'h04;
    localparam logic [7:0] BYTE_RESET      = 8'h00;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [2:0] REG_RESET       = 3'h0;
    // Extension byte counts after the mode byte
    localparam logic [1:0] EXT_NONE        = 2'h0;
    localparam logic [1:0] EXT_ONE         = 2'h1;
    localparam logic [1:0] EXT_TWO         = 2'h2;

    typedef enum logic [3:0] {
        MODE_REG_DIRECT = 4'h0,
        MODE_REG_IND    = 4'h1,
        MODE_DISP8      = 4'h2,
        MODE_DISP16     = 4'h3,
        MODE_PREDEC     = 4'h4,
        MODE_POSTINC    = 4'h5,
        MODE_ABS8       = 4'h6,
        MODE_ABS16      = 4'h7,
        MODE_IMM8       = 4'h8,
        MODE_IMM16      = 4'h9,
        MODE_NONE       = 4'hF
    } addr_mode_t;

    typedef enum logic [1:0] {
        ST_MODE   = 2'b00,
        ST_EXT_HI = 2'b01,
        ST_EXT_LO = 2'b10,
        ST_OPCODE = 2'b11
    } dec_state_t;
endpackage : ea_decode_pkg

//--- design/ea_decoder.sv
// General-format operand decoder: mode byte, extension bytes, opcode byte
//
// What this block does
// [RQ1] Mode byte, extension high-then-low, then opcode
// [RQ2] Decode direct, predecrement, postincrement, displacement modes
// [RQ3] 1101 is register indirect; 00100 opcode adds
// [RQ4] 0000/0001 Sz 101 are short/long absolute
// [RQ5] Size bit clear byte, set word
// [RQ6] Register field picks R0..R7; byte uses low
// [RQ7] Unknown mode byte flags illegal instruction
`timescale 1ns/10ps
module ea_decoder
    import ea_decode_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    input  wire logic [7:0] byte_i,
    input  wire logic       byte_valid_i,
    output logic            byte_ready_o,
    output logic            decode_valid_o,
    input  wire logic       decode_ready_i,
    output logic [3:0]      addr_mode_o,
    output logic            operand_size_bit_o,
    output logic            byte_lane_only_o,
    output logic [2:0]      source_register_field_o,
    output logic [15:0]     extension_o,
    output logic [7:0]      operation_code_field_o,
    output logic            is_general_add_o,
    output logic [2:0]      dest_register_o,
    output logic            illegal_o
);

    dec_state_t  state_q;
    addr_mode_t  mode_q;
    logic        size_q;
    logic [2:0]  reg_q;
    logic [15:0] ext_q;
    logic [7:0]  op_q;
    logic        out_valid_q;
    logic        illegal_q;
    logic        lane_q;
    logic        add_q;
    logic [2:0]  rd_q;

    // Mode byte classification
    function automatic addr_mode_t classify(input logic [7:0] b);
        addr_mode_t m;
        m = MODE_NONE;
        case (b[7:4])
            PFX_REG_DIRECT: m = MODE_REG_DIRECT;
            PFX_PREDEC:     m = MODE_PREDEC;
            PFX_POSTINC:    m = MODE_POSTINC;
            PFX_REG_IND:    m = MODE_REG_IND;
            PFX_DISP8:      m = MODE_DISP8;
            PFX_DISP16:     m = MODE_DISP16;
            PFX_ABS8: begin
                if (b[2:0] == ABS_LOW_BITS) begin
                    m = MODE_ABS8;
                end else if (b == IMM8_BYTE) begin
                    m = MODE_IMM8;
                end else if (b == IMM16_BYTE) begin
                    m = MODE_IMM16;
                end
            end
            PFX_ABS16: begin
                if (b[2:0] == ABS_LOW_BITS) begin
                    m = MODE_ABS16;
                end
            end
            default: m = MODE_NONE;
        endcase
        return m;
    endfunction : classify

    // Number of extension bytes per mode: 0, 1 or 2
    function automatic logic [1:0] ext_count(input addr_mode_t m);
        logic [1:0] n;
        n = EXT_NONE;
        case (m)
            MODE_DISP8, MODE_ABS8, MODE_IMM8:    n = EXT_ONE;
            MODE_DISP16, MODE_ABS16, MODE_IMM16: n = EXT_TWO;
            default:                             n = EXT_NONE;
        endcase
        return n;
    endfunction : ext_count

    // Mode byte that matched no addressing mode
    function automatic logic is_unknown(input addr_mode_t m);
        return m == MODE_NONE;
    endfunction : is_unknown

    // Opcode byte of a general add
    function automatic logic is_add_op(input logic [7:0] b);
        return b[7:3] == OP_ADD_PREFIX;
    endfunction : is_add_op

    addr_mode_t in_mode;
    logic       take;
    assign in_mode      = classify(byte_i);
    assign byte_ready_o = !out_valid_q;
    assign take         = byte_valid_i && !out_valid_q;

    // Sequencing of the byte stream
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= ST_MODE;
        end else if (take) begin
            case (state_q)
                ST_MODE: begin
                    if (is_unknown(in_mode)) begin
                        state_q <= ST_MODE; // RQ7
                    end else if (ext_count(in_mode) == EXT_TWO) begin
                        state_q <= ST_EXT_HI; // RQ1
                    end else if (ext_count(in_mode) == EXT_ONE) begin
                        state_q <= ST_EXT_LO; // RQ1
                    end else begin
                        state_q <= ST_OPCODE;
                    end
                end
                ST_EXT_HI: state_q <= ST_EXT_LO;
                ST_EXT_LO: state_q <= ST_OPCODE;
                ST_OPCODE: state_q <= ST_MODE;
                default:   state_q <= ST_MODE;
            endcase
        end
    end

    // Mode byte classification result
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            mode_q <= MODE_NONE;
        end else if (take && state_q == ST_MODE) begin
            mode_q <= in_mode; // RQ2 RQ3 RQ4
        end
    end

    // Operand size and byte-lane selection
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            size_q <= 1'b0;
            lane_q <= 1'b1;
        end else if (take && state_q == ST_MODE) begin
            size_q <= byte_i[SIZE_BIT_POS]; // RQ5
            lane_q <= !byte_i[SIZE_BIT_POS]; // RQ6
        end
    end

    // Source register number
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            reg_q <= REG_RESET;
        end else if (take && state_q == ST_MODE) begin
            reg_q <= byte_i[REG_MSB:0]; // RQ6
        end
    end

    // Extension bytes, high byte first; single byte lands low
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ext_q <= WORD_RESET;
        end else if (take) begin
            if (state_q == ST_MODE) begin
                ext_q <= WORD_RESET;
            end else if (state_q == ST_EXT_HI) begin
                ext_q <= {byte_i, BYTE_RESET}; // RQ1
            end else if (state_q == ST_EXT_LO) begin
                ext_q <= {ext_q[15:8], byte_i}; // RQ1
            end
        end
    end

    // Result handshake and illegal flag
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_valid_q <= 1'b0;
            illegal_q   <= 1'b0;
        end else if (out_valid_q) begin
            if (decode_ready_i) begin
                out_valid_q <= 1'b0;
            end
        end else if (take) begin
            if (state_q == ST_OPCODE) begin
                out_valid_q <= 1'b1;
                illegal_q   <= 1'b0;
            end else if (state_q == ST_MODE && is_unknown(in_mode)) begin
                out_valid_q <= 1'b1;
                illegal_q   <= 1'b1; // RQ7
            end
        end
    end

    // Opcode byte and its add decode; cleared for an illegal mode byte
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            op_q  <= BYTE_RESET;
            add_q <= 1'b0;
            rd_q  <= REG_RESET;
        end else if (take) begin
            if (state_q == ST_OPCODE) begin
                op_q  <= byte_i; // RQ1
                add_q <= is_add_op(byte_i); // RQ3
                rd_q  <= byte_i[2:0]; // RQ3
            end else if (state_q == ST_MODE && is_unknown(in_mode)) begin
                op_q  <= BYTE_RESET;
                add_q <= 1'b0;
                rd_q  <= REG_RESET;
            end
        end
    end

    // Outputs straight from flops
    assign decode_valid_o          = out_valid_q;
    assign addr_mode_o             = mode_q;
    assign operand_size_bit_o      = size_q; // RQ5
    assign byte_lane_only_o        = lane_q; // RQ6
    assign source_register_field_o = reg_q;
    assign extension_o             = ext_q;
    assign operation_code_field_o  = op_q;
    assign illegal_o               = illegal_q;
    assign is_general_add_o        = add_q; // RQ3
    assign dest_register_o         = rd_q; // RQ3

endmodule : ea_decoder

//--- tb/ea_decoder_monitor.sv
// Port checker for the operand decoder
`timescale 1ns/10ps
module ea_decoder_monitor (
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic [7:0]  byte_i,
    input wire logic        byte_valid_i,
    input wire logic        byte_ready_o,
    input wire logic        decode_valid_o,
    input wire logic        decode_ready_i,
    input wire logic [3:0]  addr_mode_o,
    input wire logic        operand_size_bit_o,
    input wire logic        byte_lane_only_o,
    input wire logic [2:0]  source_register_field_o,
    input wire logic [15:0] extension_o,
    input wire logic [7:0]  operation_code_field_o,
    input wire logic        is_general_add_o,
    input wire logic [2:0]  dest_register_o,
    input wire logic        illegal_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_accept;
        decode_valid_o && decode_ready_i;
    endsequence
    sequence s_next;
        s_accept ##1 byte_valid_i;
    endsequence
    a_ready_busy: assert property (byte_ready_o == !decode_valid_o)
        else $error("ready while busy");
    a_result_holds: assert property (decode_valid_o && !decode_ready_i |=>
        decode_valid_o && $stable(extension_o)) else $error("result lost");
    a_accept_drops: assert property (s_accept |=> !decode_valid_o)
        else $error("valid after accept");
    a_add_flag: assert property (decode_valid_o |-> is_general_add_o ==
        (operation_code_field_o[7:3] == 5'h04 && !illegal_o)
        && dest_register_o == operation_code_field_o[2:0]) else $error("add flag");
    a_lane_size: assert property (byte_lane_only_o != operand_size_bit_o)
        else $error("lane");
    a_illegal_mode: assert property (s_next ##0 byte_i == 8'h20 |=>
        decode_valid_o && illegal_o && addr_mode_o == 4'hF) else $error("illegal");
    a_direct_fields: assert property (s_next ##0 byte_i[7:4] == 4'hA ##1 byte_valid_i
        |=> addr_mode_o == 4'h0 && operand_size_bit_o == $past(byte_i[3], 2)
        && source_register_field_o == $past(byte_i[2:0], 2)) else $error("direct");
    a_short_abs: assert property (s_next ##0 byte_i == 8'h0D ##1 byte_valid_i[*2]
        |=> addr_mode_o == 4'h6 && extension_o == {8'h00, $past(byte_i, 2)})
        else $error("short abs");
endmodule : ea_decoder_monitor

//--- tb/fetch_unit_model.sv
// Fetch unit model offering instruction bytes
`timescale 1ns/10ps
module fetch_unit_model (
    input  wire logic  clk_i,
    input  wire logic  byte_ready_i,
    output logic [7:0] byte_o,
    output logic       byte_valid_o
);
    initial begin
        byte_o = 8'h00;
        byte_valid_o = 1'b0;
    end
    task automatic send(input logic [7:0] q[$], input int gap, output bit ok);
        int n;
        ok = 1'b1;
        foreach (q[i]) begin
            if (gap > 0 && i > 0) begin
                byte_valid_o <= 1'b0;
                byte_o <= ~q[i-1];
                repeat (gap) @(posedge clk_i);
            end
            byte_o <= q[i];
            byte_valid_o <= 1'b1;
            for (n = 0; n < 30; n++) begin
                @(posedge clk_i);
                if (byte_ready_i === 1'b1) break;
            end
            if (n == 30) ok = 1'b0;
        end
        byte_valid_o <= 1'b0;
        byte_o <= ~q[q.size()-1];
    endtask : send
endmodule : fetch_unit_model

//--- tb/ea_decoder_tb.sv
// Self-checking bench for the operand decoder
`timescale 1ns/10ps
module ea_decoder_tb;
    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        decode_ready_i = 1'b0;
    logic [7:0]  byte_i, operation_code_field_o;
    logic        byte_valid_i, byte_ready_o, decode_valid_o, operand_size_bit_o;
    logic        byte_lane_only_o, is_general_add_o, illegal_o;
    logic [2:0]  source_register_field_o, dest_register_o;
    logic [3:0]  addr_mode_o;
    logic [15:0] extension_o;
    int          err_count = 0;
    int          checked = 0;
    always #5 clk_i = ~clk_i;
    ea_decoder dut (.*);
    fetch_unit_model fetch (.clk_i, .byte_ready_i(byte_ready_o), .byte_o(byte_i),
        .byte_valid_o(byte_valid_i));
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic complete_run();
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : complete_run
    task automatic run(input logic [7:0] q[$], input int gap, input logic [3:0] mode,
                       input logic [15:0] ext, input logic [7:0] op);
        bit ok;
        int n;
        logic [7:0] m;
        m = q[0];
        fetch.send(q, gap, ok);
        for (n = 0; n < 20 && decode_valid_o !== 1'b1; n++) @(posedge clk_i);
        if (!ok || n == 20) begin
            cmp(1'b0, 1'b1);
            complete_run();
        end
        cmp(addr_mode_o, mode);
        cmp(extension_o, ext);
        cmp(operation_code_field_o, op);
        cmp(illegal_o, mode == 4'hF);
        cmp(is_general_add_o, op[7:3] == 5'h04 && mode != 4'hF);
        cmp(dest_register_o, op[2:0]);
        if (mode != 4'hF) begin
            cmp(operand_size_bit_o, m[3]);
            cmp(source_register_field_o, m[2:0]);
            cmp(byte_lane_only_o, !m[3]);
        end
        repeat (2) @(posedge clk_i);
        cmp(byte_ready_o, 1'b0);
        decode_ready_i <= 1'b1;
        @(posedge clk_i);
        decode_ready_i <= 1'b0;
    endtask : run
    task automatic sc_examples();
        run('{8'hD0, 8'h21}, 0, 4'h1, 16'h0000, 8'h21);
        run('{8'hAF, 8'h21}, 0, 4'h0, 16'h0000, 8'h21);
        run('{8'h0D, 8'h11, 8'h21}, 0, 4'h6, 16'h0011, 8'h21);
        run('{8'h1D, 8'h12, 8'h34, 8'h20}, 0, 4'h7, 16'h1234, 8'h20);
    endtask : sc_examples
    task automatic sc_ext();
        run('{8'hF2, 8'hAB, 8'hCD, 8'h27}, 2, 4'h3, 16'hABCD, 8'h27);
        run('{8'hE9, 8'h80, 8'h21}, 1, 4'h2, 16'h0080, 8'h21);
        run('{8'hB8, 8'h21}, 0, 4'h4, 16'h0000, 8'h21);
        run('{8'hC3, 8'h90}, 0, 4'h5, 16'h0000, 8'h90);
        run('{8'h04, 8'h55, 8'h21}, 0, 4'h8, 16'h0055, 8'h21);
        run('{8'h0C, 8'h12, 8'h34, 8'h21}, 0, 4'h9, 16'h1234, 8'h21);
    endtask : sc_ext
    task automatic sc_illegal();
        run('{8'h20}, 0, 4'hF, 16'h0000, 8'h00);
        run('{8'h08}, 0, 4'hF, 16'h0000, 8'h00);
    endtask : sc_illegal
    initial begin
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        cmp(decode_valid_o, 1'b0);
        cmp(addr_mode_o, 4'hF);
        sc_examples();
        sc_ext();
        sc_illegal();
        complete_run();
    end
endmodule : ea_decoder_tb
bind ea_decoder ea_decoder_monitor mon (.*);
